// ---- tmr_cha_ctrl.sv ----
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module tmr_cha_ctrl (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_high_clk_tick,
    input wire logic i_time_base_tick,
    input wire logic i_ext_counter_clock_pin,
    input wire logic i_channel_a_pin,
    output logic o_channel_a_pin,
    output logic o_channel_a_pin_oe_n,
    output logic o_compare_match,
    output logic o_period_match,
    output logic o_capture_strobe,
    output logic [9:0] o_count
);

    // **********************************************
    // declarations
    // **********************************************
    tmr_pkg::ctrl0_s ctrl0_r;
    tmr_pkg::ctrl1_s ctrl1_r;
    logic [9:0] cmpa_r;
    logic [9:0] cnt_r;
    logic [9:0] cnt_nxt;
    logic [9:0] cnt_inc;
    logic run_d_r;
    logic [1:0] sys_div_r;
    logic [5:0] high_div_r;
    logic ext_d_r;
    logic pin_d_r;
    logic lvl_r;
    logic pulse_r;
    logic cnt_tick;
    logic start;
    logic adv;
    logic per_hit;
    logic a_hit;
    logic use_a;
    logic cap_evt;
    logic pin_raw;
    logic drive;
    logic bus_wr;
    logic bus_rd;

    // address decode, used only by the error answer; the read mux has its own case
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == tmr_pkg::OFS_CTRL0) || (a == tmr_pkg::OFS_CTRL1) ||
                 (a == tmr_pkg::OFS_CMPA) || (a == tmr_pkg::OFS_COUNT);
    endfunction : mapped

    // **********************************************
    // apb slave
    // **********************************************
    // zero wait states: every access completes in its first access cycle
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !mapped(i_paddr);
    assign bus_wr = i_psel && i_penable && i_pwrite;
    assign bus_rd = i_psel && !i_penable && !i_pwrite;

    // read data captured in setup so it stands through the access cycle
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            o_prdata <= 32'h0;
        end else if (bus_rd) begin
            unique case (i_paddr)
                tmr_pkg::OFS_CTRL0: o_prdata <= {24'h0, ctrl0_r};
                tmr_pkg::OFS_CTRL1: o_prdata <= {24'h0, ctrl1_r};
                tmr_pkg::OFS_CMPA: o_prdata <= {22'h0, cmpa_r};
                tmr_pkg::OFS_COUNT: o_prdata <= {22'h0, cnt_r};
                default: o_prdata <= 32'h0;
            endcase
        end
    end

    // control registers; direction flag ignores writes
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            ctrl0_r <= tmr_pkg::ctrl0_s'(tmr_pkg::CTRL_RESET);
            ctrl1_r <= tmr_pkg::ctrl1_s'(tmr_pkg::CTRL_RESET);
        end else if (bus_wr && i_paddr == tmr_pkg::OFS_CTRL0) begin
            ctrl0_r <= tmr_pkg::ctrl0_s'(i_pwdata[7:0]);
        end else if (bus_wr && i_paddr == tmr_pkg::OFS_CTRL1) begin
            ctrl1_r <= tmr_pkg::ctrl1_s'({i_pwdata[7:2], tmr_pkg::COUNT_UP, i_pwdata[0]});
        end
    end

    // compare A value; a capture overwrites it and wins over a write
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            cmpa_r <= tmr_pkg::CMPA_RESET;
        end else if (cap_evt) begin
            cmpa_r <= cnt_r;
        end else if (bus_wr && i_paddr == tmr_pkg::OFS_CMPA) begin
            cmpa_r <= i_pwdata[9:0];
        end
    end

    // **********************************************
    // counter clock selection
    // **********************************************
    // fixed divide of the core clock and of the high clock tick
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            sys_div_r <= 2'h0;
            high_div_r <= 6'h0;
        end else begin
            sys_div_r <= sys_div_r + 2'h1;
            if (i_high_clk_tick) begin
                high_div_r <= high_div_r + 6'h1;
            end
        end
    end

    // pin samples kept for edge detection; pins are already synchronous
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            ext_d_r <= 1'b0;
            pin_d_r <= 1'b0;
        end else begin
            ext_d_r <= i_ext_counter_clock_pin;
            pin_d_r <= i_channel_a_pin;
        end
    end

    // one tick per active edge of the chosen source
    always_comb begin
        unique case (ctrl0_r.clk_sel)
            tmr_pkg::CLK_SYS_DIV4: cnt_tick = sys_div_r == tmr_pkg::SYS_DIV_LAST;
            tmr_pkg::CLK_SYS: cnt_tick = 1'b1;
            tmr_pkg::CLK_HIGH_DIV16: cnt_tick = i_high_clk_tick && high_div_r[3:0] == tmr_pkg::HIGH16_LAST;
            tmr_pkg::CLK_HIGH_DIV64: cnt_tick = i_high_clk_tick && high_div_r == tmr_pkg::HIGH64_LAST;
            tmr_pkg::CLK_TIME_BASE: cnt_tick = i_time_base_tick;
            tmr_pkg::CLK_RSVD: cnt_tick = 1'b0;
            tmr_pkg::CLK_PIN_RISE: cnt_tick = i_ext_counter_clock_pin && !ext_d_r;
            tmr_pkg::CLK_PIN_FALL: cnt_tick = !i_ext_counter_clock_pin && ext_d_r;
        endcase
    end

    // **********************************************
    // counter and comparators
    // **********************************************
    // run edge seen one cycle after the register write
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            run_d_r <= 1'b0;
        end else begin
            run_d_r <= ctrl0_r.run;
        end
    end

    assign start = ctrl0_r.run && !run_d_r;
    assign adv = ctrl0_r.run && !ctrl0_r.pause && cnt_tick && !start;
    assign cnt_inc = cnt_r + 10'h1;
    // period zero gives a target of zero, which is the natural wrap
    assign per_hit = cnt_inc == {ctrl0_r.period, 7'h0};
    assign a_hit = cnt_inc == cmpa_r;
    // clear source only honoured in compare output and timer modes
    assign use_a = ctrl1_r.clr_sel && (ctrl1_r.mode == tmr_pkg::MODE_CMP_OUT ||
                                       ctrl1_r.mode == tmr_pkg::MODE_TIMER);

    // next count: start clear first, then match clear, else increment
    always_comb begin
        cnt_nxt = cnt_r;
        if (start) begin
            cnt_nxt = 10'h0;
        end else if (adv) begin
            if (use_a ? a_hit : per_hit) begin
                cnt_nxt = 10'h0;
            end else begin
                cnt_nxt = cnt_inc;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            cnt_r <= 10'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // match events as pulses for the interrupt logic elsewhere
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            o_compare_match <= 1'b0;
            o_period_match <= 1'b0;
        end else begin
            o_compare_match <= adv && a_hit;
            o_period_match <= adv && per_hit;
        end
    end

    // **********************************************
    // capture input
    // **********************************************
    // only while running; code three disables capture altogether
    always_comb begin
        cap_evt = 1'b0;
        if (ctrl0_r.run && ctrl1_r.mode == tmr_pkg::MODE_CAPTURE) begin
            unique case (ctrl1_r.pin_fn)
                tmr_pkg::CAP_RISE: cap_evt = i_channel_a_pin && !pin_d_r;
                tmr_pkg::CAP_FALL: cap_evt = !i_channel_a_pin && pin_d_r;
                tmr_pkg::CAP_BOTH: cap_evt = i_channel_a_pin != pin_d_r;
                default: cap_evt = 1'b0;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            o_capture_strobe <= 1'b0;
        end else begin
            o_capture_strobe <= cap_evt;
        end
    end

    // **********************************************
    // channel A output
    // **********************************************
    // compare output level; a request equal to the initial level does nothing
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            lvl_r <= 1'b0;
        end else if (ctrl1_r.mode == tmr_pkg::MODE_CMP_OUT) begin
            if (start) begin
                lvl_r <= ctrl1_r.init_lvl;
            end else if (adv && a_hit) begin
                unique case (ctrl1_r.pin_fn)
                    tmr_pkg::PF_KEEP: lvl_r <= lvl_r;
                    tmr_pkg::PF_LOW: lvl_r <= ctrl1_r.init_lvl ? 1'b0 : lvl_r;
                    tmr_pkg::PF_HIGH: lvl_r <= ctrl1_r.init_lvl ? lvl_r : 1'b1;
                    tmr_pkg::PF_TOGGLE: lvl_r <= !lvl_r;
                endcase
            end
        end
    end

    // single pulse window: from start until the compare A match
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            pulse_r <= 1'b0;
        end else if (start) begin
            pulse_r <= 1'b1;
        end else if (adv && a_hit) begin
            pulse_r <= 1'b0;
        end
    end

    // pwm active state expressed through the initial-level bit
    always_comb begin
        pin_raw = 1'b0;
        drive = 1'b0;
        unique case (ctrl1_r.mode)
            tmr_pkg::MODE_CMP_OUT: begin
                pin_raw = lvl_r;
                drive = 1'b1;
            end
            tmr_pkg::MODE_PWM: begin
                drive = 1'b1;
                unique case (ctrl1_r.pin_fn)
                    tmr_pkg::PF_INACTIVE: pin_raw = !ctrl1_r.init_lvl;
                    tmr_pkg::PF_ACTIVE: pin_raw = ctrl1_r.init_lvl;
                    // xnor with the level bit: active high passes the window, active low inverts it
                    tmr_pkg::PF_PWM: pin_raw = (cnt_r < cmpa_r) ~^ ctrl1_r.init_lvl;
                    tmr_pkg::PF_SINGLE: pin_raw = pulse_r ~^ ctrl1_r.init_lvl;
                endcase
            end
            tmr_pkg::MODE_CAPTURE: drive = 1'b0;
            tmr_pkg::MODE_TIMER: drive = 1'b0;
        endcase
    end

    // registered pin; released (enable high) whenever not driving
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            o_channel_a_pin <= 1'b0;
            o_channel_a_pin_oe_n <= 1'b1;
        end else begin
            o_channel_a_pin <= drive && (pin_raw ^ ctrl1_r.polarity);
            o_channel_a_pin_oe_n <= !drive;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            o_count <= 10'h0;
        end else begin
            o_count <= cnt_nxt;
        end
    end

    // **********************************************
    // assertions
    // **********************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    sequence cmp_start_s;
        start && ctrl1_r.mode == tmr_pkg::MODE_CMP_OUT;
    endsequence

    sequence plain_step_s;
        adv && !per_hit && !a_hit;
    endsequence

    rsvd_clock_a: assert property ((ctrl0_r.clk_sel == tmr_pkg::CLK_RSVD && !start) |=> $stable(cnt_r))
        else $error("counter moved with reserved clock");
    run_hold_a: assert property ((!ctrl0_r.run) |=> $stable(cnt_r))
        else $error("counter moved while stopped");
    run_clear_a: assert property ($rose(ctrl0_r.run) |=> cnt_r == 10'h0)
        else $error("counter not cleared on start");
    init_level_a: assert property (cmp_start_s |=> lvl_r == $past(ctrl1_r.init_lvl) ##1
                                   ($past(ctrl1_r.mode) != tmr_pkg::MODE_CMP_OUT ||
                                    o_channel_a_pin == ($past(lvl_r) ^ $past(ctrl1_r.polarity))))
        else $error("output not restored to initial level");
    period_wrap_a: assert property ((adv && ctrl0_r.period == 3'h0 && !use_a && cnt_r == 10'h3ff)
                                    |=> cnt_r == 10'h0 && o_period_match)
        else $error("no wrap at maximum count");
    period_clear_a: assert property ((adv && !use_a && cnt_inc == {ctrl0_r.period, 7'h0})
                                     |=> cnt_r == 10'h0)
        else $error("period match did not clear");
    pause_hold_a: assert property ((ctrl0_r.pause && !start) |=> $stable(cnt_r))
        else $error("counter moved while paused");
    step_up_a: assert property (plain_step_s |=> cnt_r == $past(cnt_inc))
        else $error("counter did not advance by one");
    timer_idle_a: assert property ((ctrl1_r.mode == tmr_pkg::MODE_TIMER) |=> o_channel_a_pin_oe_n)
        else $error("pin driven in timer mode");
    dir_flag_a: assert property (ctrl1_r.count_dir == tmr_pkg::COUNT_UP)
        else $error("direction flag changed");
    capture_a: assert property (cap_evt |=> cmpa_r == $past(cnt_r) && o_capture_strobe)
        else $error("capture did not latch count");

endmodule : tmr_cha_ctrl

// ---- tmr_cha_ctrl_tb.sv ----
`timescale 1ns/1ps
module tmr_cha_ctrl_tb;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic high_tick = 1'b0;
    logic tbase_tick = 1'b0;
    logic ext_pin = 1'b0;
    logic cha_in = 1'b0;
    logic [15:0] cyc = 16'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cha_out;
    logic cha_oe_n;
    logic cmp_match;
    logic per_match;
    logic cap_strobe;
    logic [9:0] count;
    logic [31:0] rd;
    logic er;
    logic [31:0] snap;
    int err_count = 0;
    int checks = 0;
    int n;
    logic fn_exp [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic [2:0] per_code [3] = '{3'h1, 3'h7, 3'h0};
    int per_len [3] = '{128, 896, 1024};

    tmr_cha_ctrl i_tmr_cha_ctrl (.i_core_clk(core_clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_high_clk_tick(high_tick), .i_time_base_tick(tbase_tick),
        .i_ext_counter_clock_pin(ext_pin), .i_channel_a_pin(cha_in), .o_channel_a_pin(cha_out),
        .o_channel_a_pin_oe_n(cha_oe_n), .o_compare_match(cmp_match), .o_period_match(per_match),
        .o_capture_strobe(cap_strobe), .o_count(count));

    // ****************************************
    // clock and free-running tick sources
    // ****************************************
    always #2.5 core_clk = ~core_clk;

    // ticks are fast enough that every clock source but the reserved code advances within a few hundred cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 16'h1;
        high_tick <= (cyc[0] == 1'b0);
        tbase_tick <= (cyc[2:0] == 3'h0);
        ext_pin <= cyc[2];
    end

    // ****************************************
    // checking and bus tasks
    // ****************************************
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", err_count, checks);
        if (err_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    // entered and left just after a rising edge; psel rests one cycle between transfers
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            err_count++;
            give_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, {24'h0, d});
    endtask : wr

    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(name, rd, exp);
    endtask : rdchk

    // which: 0 period match, 1 compare match, 2 capture strobe; cycles to the pulse land in n
    task automatic wait_hi(input int which, input int lim);
        logic s;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
            s = (which == 0) ? per_match : (which == 1) ? cmp_match : cap_strobe;
        end while (s !== 1'b1 && n < lim);
        if (n >= lim) begin
            err_count++;
            give_verdict();
        end
    endtask : wait_hi

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        rdchk("ctrl0", tmr_pkg::OFS_CTRL0, 32'h0);
        rdchk("ctrl1", tmr_pkg::OFS_CTRL1, 32'h0);
        rdchk("cmpa", tmr_pkg::OFS_CMPA, 32'h0);
        rdchk("count", tmr_pkg::OFS_COUNT, 32'h0);
        wr(8'h10, 8'hff);
        chk("unmapped err", {31'h0, er}, 32'h1);
        rdchk("unmapped rd", 8'h10, 32'h0);
        chk("unmapped rd err", {31'h0, er}, 32'h1);
        wr(tmr_pkg::OFS_CTRL1, 8'h02);
        rdchk("direction flag", tmr_pkg::OFS_CTRL1, 32'h0);
        // every clock source advances the count except the reserved code
        for (int c = 0; c < 8; c++) begin
            wr(tmr_pkg::OFS_CTRL0, 8'h00);
            wr(tmr_pkg::OFS_CTRL0, {1'b0, c[2:0], 4'h8});
            repeat (400) @(posedge core_clk);
            wr(tmr_pkg::OFS_CTRL0, 8'h00);
            xfer(1'b0, tmr_pkg::OFS_COUNT, 32'h0);
            chk("source ticks", {31'h0, rd != 32'h0}, {31'h0, c != 5});
        end
        snap = rd;
        repeat (20) @(posedge core_clk);
        rdchk("stopped count", tmr_pkg::OFS_COUNT, snap);
        chk("count port", {22'h0, count}, snap);
        wr(tmr_pkg::OFS_CTRL0, 8'h18);
        xfer(1'b0, tmr_pkg::OFS_COUNT, 32'h0);
        chk("cleared on start", {31'h0, rd <= 32'h4}, 32'h1);
        wr(tmr_pkg::OFS_CTRL0, 8'h98);
        xfer(1'b0, tmr_pkg::OFS_COUNT, 32'h0);
        snap = rd;
        repeat (20) @(posedge core_clk);
        rdchk("paused count", tmr_pkg::OFS_COUNT, snap);
        wr(tmr_pkg::OFS_CTRL0, 8'h18);
        xfer(1'b0, tmr_pkg::OFS_COUNT, 32'h0);
        chk("resumed count", {31'h0, rd > snap && rd < snap + 8}, 32'h1);
        // period lengths, clear source 0
        for (int p = 0; p < 3; p++) begin
            wr(tmr_pkg::OFS_CTRL0, 8'h00);
            wr(tmr_pkg::OFS_CTRL0, {5'h3, per_code[p]});
            wait_hi(0, 1100);
            wait_hi(0, 1100);
            chk("period length", n, per_len[p]);
        end
        // capture mode ignores the clear source: period still governs
        wr(tmr_pkg::OFS_CTRL0, 8'h00);
        wr(tmr_pkg::OFS_CTRL1, 8'h41);
        wr(tmr_pkg::OFS_CTRL0, 8'h19);
        wait_hi(0, 300);
        wait_hi(0, 300);
        chk("capture mode period", n, 128);
        chk("capture pin released", {31'h0, cha_oe_n}, 32'h1);
        cha_in <= 1'b1;
        wait_hi(2, 10);
        xfer(1'b0, tmr_pkg::OFS_CMPA, 32'h0);
        chk("captured value", {31'h0, rd != 32'h0}, 32'h1);
        // capture disabled code never strobes
        wr(tmr_pkg::OFS_CTRL0, 8'h00);
        wr(tmr_pkg::OFS_CTRL1, 8'h70);
        wr(tmr_pkg::OFS_CTRL0, 8'h18);
        n = 0;
        for (int k = 0; k < 40; k++) begin
            @(posedge core_clk);
            cha_in <= k[2];
            if (cap_strobe === 1'b1) n++;
        end
        chk("capture disabled", n, 0);
        // compare clears the counter when the clear source is 1
        wr(tmr_pkg::OFS_CTRL0, 8'h00);
        xfer(1'b1, tmr_pkg::OFS_CMPA, 32'd20);
        wr(tmr_pkg::OFS_CTRL1, 8'hc1);
        wr(tmr_pkg::OFS_CTRL0, 8'h18);
        wait_hi(1, 100);
        wait_hi(1, 100);
        chk("compare period", n, 20);
        n = 0;
        repeat (200) begin
            @(posedge core_clk);
            if (cha_oe_n !== 1'b1) n++;
        end
        chk("timer pin released", n, 0);
        // pin function on compare match, initial level 0
        for (int f = 0; f < 4; f++) begin
            wr(tmr_pkg::OFS_CTRL0, 8'h00);
            wr(tmr_pkg::OFS_CTRL1, {2'h0, f[1:0], 4'h1});
            wr(tmr_pkg::OFS_CTRL0, 8'h18);
            // level loads one edge after start, the pin one edge later
            repeat (2) @(posedge core_clk);
            chk("start level", {31'h0, cha_out}, 32'h0);
            chk("pin driven", {31'h0, cha_oe_n}, 32'h0);
            wait_hi(1, 100);
            repeat (3) @(posedge core_clk);
            chk("match action", {31'h0, cha_out}, {31'h0, fn_exp[f]});
        end
        // polarity inverts the restored level
        wr(tmr_pkg::OFS_CTRL0, 8'h00);
        wr(tmr_pkg::OFS_CTRL1, 8'h35);
        wr(tmr_pkg::OFS_CTRL0, 8'h18);
        repeat (2) @(posedge core_clk);
        chk("inverted start", {31'h0, cha_out}, 32'h1);
        // requested level equal to initial level leaves the pin alone
        wr(tmr_pkg::OFS_CTRL0, 8'h00);
        wr(tmr_pkg::OFS_CTRL1, 8'h29);
        wr(tmr_pkg::OFS_CTRL0, 8'h18);
        wait_hi(1, 100);
        repeat (3) @(posedge core_clk);
        chk("equal level kept", {31'h0, cha_out}, 32'h1);
        // pwm held levels, active high
        for (int f = 0; f < 2; f++) begin
            wr(tmr_pkg::OFS_CTRL0, 8'h00);
            wr(tmr_pkg::OFS_CTRL1, {2'h2, f[1:0], 4'h8});
            wr(tmr_pkg::OFS_CTRL0, 8'h18);
            repeat (30) @(posedge core_clk);
            chk("pwm held level", {31'h0, cha_out}, f);
        end
        // pwm and single pulse, active high, compare A 20, period 128; clear source 1 ignored
        for (int f = 2; f < 4; f++) begin
            wr(tmr_pkg::OFS_CTRL0, 8'h00);
            wr(tmr_pkg::OFS_CTRL1, {2'h2, f[1:0], 4'h9});
            wr(tmr_pkg::OFS_CTRL0, 8'h19);
            @(posedge core_clk);
            n = 0;
            repeat (128) begin
                @(posedge core_clk);
                if (cha_out === 1'b1) n++;
            end
            chk("pwm high cycles", n, 20);
        end
        give_verdict();
    end
endmodule : tmr_cha_ctrl_tb

// ---- tmr_pkg.sv ----
// **********************************************
// **********************************************
package tmr_pkg;
    localparam int CNT_W = 10;
    localparam int PER_LSB = 7; // period compares bits 9..7
    // register byte offsets
    localparam logic [7:0] OFS_CTRL0 = 8'h00;
    localparam logic [7:0] OFS_CTRL1 = 8'h04;
    localparam logic [7:0] OFS_CMPA = 8'h08;
    localparam logic [7:0] OFS_COUNT = 8'h0c;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [9:0] CMPA_RESET = 10'h000;
    localparam logic COUNT_UP = 1'b0;
    // prescaler terminal counts
    localparam logic [1:0] SYS_DIV_LAST = 2'h3;
    localparam logic [3:0] HIGH16_LAST = 4'hf;
    localparam logic [5:0] HIGH64_LAST = 6'h3f;
    // pin function codes per mode
    localparam logic [1:0] PF_KEEP = 2'h0;
    localparam logic [1:0] PF_LOW = 2'h1;
    localparam logic [1:0] PF_HIGH = 2'h2;
    localparam logic [1:0] PF_TOGGLE = 2'h3;
    localparam logic [1:0] PF_INACTIVE = 2'h0;
    localparam logic [1:0] PF_ACTIVE = 2'h1;
    localparam logic [1:0] PF_PWM = 2'h2;
    localparam logic [1:0] PF_SINGLE = 2'h3;
    localparam logic [1:0] CAP_RISE = 2'h0;
    localparam logic [1:0] CAP_FALL = 2'h1;
    localparam logic [1:0] CAP_BOTH = 2'h2;

    typedef enum logic [2:0] {
        CLK_SYS_DIV4, CLK_SYS, CLK_HIGH_DIV16, CLK_HIGH_DIV64,
        CLK_TIME_BASE, CLK_RSVD, CLK_PIN_RISE, CLK_PIN_FALL
    } clk_sel_e;

    typedef enum logic [1:0] {
        MODE_CMP_OUT, MODE_CAPTURE, MODE_PWM, MODE_TIMER
    } cha_mode_e;

    typedef struct packed {
        logic pause;
        clk_sel_e clk_sel;
        logic run;
        logic [2:0] period;
    } ctrl0_s;

    typedef struct packed {
        cha_mode_e mode;
        logic [1:0] pin_fn;
        logic init_lvl;
        logic polarity;
        logic count_dir;
        logic clr_sel;
    } ctrl1_s;
endpackage : tmr_pkg
